// file: src/scr_clkout_div.sv
// Purpose: Square-wave clock output divided from the bus clock.
// Assumes: Select and enable come from registers on the same clock.
// Notes:   Output is a flip-flop; held low when off or select is zero.
`timescale 1ns/1ps
module scr_clkout_div
  import scr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       en_i,
  input  wire logic [2:0] sel_i,
  // Clock out
  output logic            clk_o
);

  scr_div_state_type s_q;
  scr_div_state_type s_d;

  // Toggle every sel cycles, so one period is twice the select value.
  always_comb
  begin
    s_d = s_q;
    if (!en_i || (sel_i == 3'h0))
    begin
      s_d.cnt = 3'h0;
      s_d.clk = 1'b0; // RULE_03
    end
    else if (s_q.cnt >= 3'(sel_i - 3'h1))
    begin
      s_d.cnt = 3'h0;
      s_d.clk = ~s_q.clk; // RULE_02 RULE_15
    end
    else
    begin
      s_d.cnt = 3'(s_q.cnt + 3'h1);
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign clk_o = s_q.clk;

endmodule : scr_clkout_div

// file: src/scr_defs.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 32-bit APB words, one register per aligned word.
// Notes:   Definitions only.
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define SCR_OFF_CLKOUT   12'h000
`define SCR_OFF_PARTID   12'h004
`define SCR_OFF_PMSC1    12'h008
`define SCR_OFF_WAKE     12'h00C
`define SCR_OFF_IRQ_STAT 12'h010
`define SCR_OFF_IRQ_CLR  12'h014
`define SCR_OFF_IRQ_EN   12'h018

// ************************************************************
// Field positions
// ************************************************************
`define SCR_CLKOUT_EN_BIT 4
`define SCR_PM_FLAG_BIT   7
`define SCR_PM_ACK_BIT    6
`define SCR_PM_IRQEN_BIT  5
`define SCR_PM_RSTEN_BIT  4
`define SCR_PM_STOPEN_BIT 3
`define SCR_PM_DETEN_BIT  2
`define SCR_PM_BGEN_BIT   0
`define SCR_WAKE_EXT_BIT  3
`define SCR_IRQ_LOWV_BIT  0
`define SCR_IRQ_WAKE_BIT  1

// ************************************************************
// Reset values and identity
// ************************************************************
`define SCR_PM_RESET     8'h1C
`define SCR_PART_ID      12'h5A3
`define SCR_PM_ONCE_MASK 8'h1C

// ************************************************************
// Timing
// ************************************************************
`define SCR_CLK_HZ      25000000
`define SCR_TICK_US     1000
`define SCR_TICK_CYCLES ((`SCR_CLK_HZ / 1000000) * `SCR_TICK_US)

`endif

// file: src/scr_pkg.sv
// Purpose: Types shared by the system-control register block.
// Assumes: Constants live in scr_defs.svh.
// Notes:   Each module keeps its state in one struct below, apart from rst_sync_q in scr_top.
package scr_pkg;

  // ************************************************************
  // Clock-output divider state
  // ************************************************************
  typedef struct packed {
    logic [2:0] cnt;
    logic       clk;
  } scr_div_state_type;

  // ************************************************************
  // Wakeup timer state
  // ************************************************************
  typedef struct packed {
    logic [15:0] cnt;
    logic        wake;
  } scr_wake_state_type;

  // ************************************************************
  // Top state
  // ************************************************************
  typedef struct packed {
    logic [1:0]  lv_sync;
    logic [1:0]  ext_sync;
    logic        ext_last;
    logic [14:0] tick_cnt;
    logic        tick;
    logic        clkout_en;
    logic [2:0]  clkout_sel;
    logic        lowv_flag;
    logic        lowv_irq_en;
    logic        lowv_rst_en;
    logic        lowv_stop_en;
    logic        lowv_det_en;
    logic        bg_en;
    logic        pm_locked;
    logic [2:0]  wake_sel;
    logic        wake_ext;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_en;
    logic        irq;
    logic        lowv_reset;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } scr_top_state_type;

endpackage : scr_pkg

// file: src/scr_top.sv
// Purpose: System-control registers: clock output, part id, wakeup timer,
//          low-voltage status with interrupt and reset requests.
// Assumes: APB master on clk_sys_i; pins arrive asynchronously.
// Notes:   Zero-wait APB slave, one setup and one access cycle.
`timescale 1ns/1ps
`include "scr_defs.svh"

// Summary of operation
// (RULE_01) Clock-output enable bit 4 routes the divided clock onto its pin.
// (RULE_02) Nonzero select gives bus clock divided by twice the select.
// (RULE_03) Zero select with enable set holds the pin low.
// (RULE_04) Upper nibble of part id high is reserved; writes change nothing.
// (RULE_05) Part id low nibble returns id bits 11:8; register is read-only.
// (RULE_06) Wakeup select zero disables the periodic wakeup timer.
// (RULE_07) Internal 1 kHz periods: 8,32,64,128,256,512 ms and 1.024 s.
// (RULE_08) External clock divides: 256 up to 32768 for codes 1 to 7.
// (RULE_09) Read-only low-voltage flag sets on events while detection enabled.
// (RULE_10) Writing acknowledge bit 6 clears the flag; it reads zero.
// (RULE_11) Interrupt enable bit 5 raises an interrupt while the flag is set.
// (RULE_12) Reset enable bit 4 with detection enabled forces reset on flag.
// (RULE_13) Software writes zero to reserved bit 1.
// (RULE_14) Write-once bits accept only the first write after reset.
// (RULE_15) Divider counts bus clocks and toggles for a 50 percent duty.
// (RULE_16) Raw low-voltage input is synchronised and sets the sticky flag.
module scr_top
  import scr_pkg::*;
#(
  parameter int TICK_CYCLES = `SCR_TICK_CYCLES
)
(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o,
  // Pins and analog monitor
  input  wire logic        lowv_detect_i,
  input  wire logic        ext_clk_i,
  output logic             clkout_port_pin_o,
  output logic             clkout_pin_enable_o,
  // System requests
  output logic             irq_o,
  output logic             lowv_reset_req_o
);

  // ************************************************************
  // Reset release
  // ************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  // Assert at once, release two edges later to avoid recovery races.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // Internal reset for every register below.
  assign rst_n = rst_sync_q[1];

  // ************************************************************
  // State and sub-blocks
  // ************************************************************
  // Power register reset image; the write-once bits 4:2 start set.
  localparam logic [7:0] PM_RESET = `SCR_PM_RESET;

  scr_top_state_type s_q;
  scr_top_state_type s_d;
  logic              div_clk;
  logic              wake_pulse;
  logic              wake_step;
  logic              ext_rise;
  logic              acc;
  logic              wr;
  logic [7:0]        wb;
  logic              pm_wr;

  // Clock output divider.
  scr_clkout_div u_div (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n),
    .en_i    (s_q.clkout_en),
    .sel_i   (s_q.clkout_sel),
    .clk_o   (div_clk)
  );

  // Periodic wakeup timer.
  scr_wakeup_timer u_wake (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n),
    .step_i  (wake_step),
    .ext_i   (s_q.wake_ext),
    .sel_i   (s_q.wake_sel),
    .wake_o  (wake_pulse)
  );

  // ************************************************************
  // Wakeup source and bus decode
  // ************************************************************
  // Source tick: a synchronised external rising edge or the 1 kHz enable.
  // The external clock must stay below half the bus clock or edges are lost.
  assign ext_rise  = s_q.ext_sync[1] & ~s_q.ext_last;
  assign wake_step = s_q.wake_ext ? ext_rise : s_q.tick;

  // APB access-phase decode; a write lands when pready is seen high.
  // A refused access carries the error flag, so it never writes a register.
  assign acc   = psel_i & penable_i & s_q.pready;
  assign wr    = acc & pwrite_i & ~s_q.pslverr;
  assign wb    = pwdata_i[7:0];
  assign pm_wr = wr & (paddr_i == `SCR_OFF_PMSC1);

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb
  begin
    s_d = s_q;

    // Two-flop synchronisers; only the second stage is looked at.
    s_d.lv_sync  = {s_q.lv_sync[0], lowv_detect_i}; // RULE_16
    s_d.ext_sync = {s_q.ext_sync[0], ext_clk_i};
    s_d.ext_last = s_q.ext_sync[1];

    // 1 kHz enable pulse from the bus clock.
    // The 15-bit counter limits TICK_CYCLES to 32768 bus clocks per tick.
    s_d.tick = 1'b0;
    if (s_q.tick_cnt >= 15'(TICK_CYCLES - 1))
    begin
      s_d.tick_cnt = 15'h0000;
      s_d.tick     = 1'b1;
    end
    else
    begin
      s_d.tick_cnt = 15'(s_q.tick_cnt + 15'h0001);
    end

    // Clock-output control; only bit 4 and bits 2:0 are stored.
    // Bits 7:5 and 3 are not stored and read back as zero.
    if (wr && (paddr_i == `SCR_OFF_CLKOUT))
    begin
      s_d.clkout_en  = wb[`SCR_CLKOUT_EN_BIT]; // RULE_01
      s_d.clkout_sel = wb[2:0];
    end

    // Wakeup control.
    // A new select does not restart the count; the next period may run short.
    if (wr && (paddr_i == `SCR_OFF_WAKE))
    begin
      s_d.wake_sel = wb[2:0];
      s_d.wake_ext = wb[`SCR_WAKE_EXT_BIT];
    end

    // Power management: plain read/write bits.
    // Reserved bit 1 is not stored; software is expected to write it as zero.
    if (pm_wr)
    begin
      s_d.lowv_irq_en = wb[`SCR_PM_IRQEN_BIT];
      s_d.bg_en       = wb[`SCR_PM_BGEN_BIT];
    end

    // Write-once bits: the first write locks them until reset.
    // Any write locks them, so a careless first write fixes detection for good.
    if (pm_wr && !s_q.pm_locked)
    begin
      s_d.lowv_rst_en  = wb[`SCR_PM_RSTEN_BIT]; // RULE_14
      s_d.lowv_stop_en = wb[`SCR_PM_STOPEN_BIT];
      s_d.lowv_det_en  = wb[`SCR_PM_DETEN_BIT];
      s_d.pm_locked    = 1'b1;
    end

    // Flag: acknowledge clears, a detected event in the same cycle wins.
    // A raw input still high keeps setting the flag, so an early ack is undone.
    if (pm_wr && wb[`SCR_PM_ACK_BIT])
    begin
      s_d.lowv_flag = 1'b0; // RULE_10
    end
    if (s_q.lv_sync[1] && s_q.lowv_det_en)
    begin
      s_d.lowv_flag = 1'b1; // RULE_09
    end

    // Sticky interrupt status; a new event beats a same-cycle clear.
    if (wr && (paddr_i == `SCR_OFF_IRQ_CLR))
    begin
      s_d.irq_stat = s_q.irq_stat & ~wb[1:0];
    end
    if (s_q.lv_sync[1] && s_q.lowv_det_en)
    begin
      s_d.irq_stat[`SCR_IRQ_LOWV_BIT] = 1'b1;
    end
    if (wake_pulse)
    begin
      s_d.irq_stat[`SCR_IRQ_WAKE_BIT] = 1'b1;
    end
    if (wr && (paddr_i == `SCR_OFF_IRQ_EN))
    begin
      s_d.irq_en = wb[1:0];
    end

    // Interrupt and reset requests follow the registered flag.
    // Registering them costs a cycle but keeps both outputs glitch free.
    s_d.irq = (s_q.lowv_flag & s_q.lowv_irq_en) // RULE_11
            | (|(s_q.irq_stat & s_q.irq_en));
    s_d.lowv_reset = s_q.lowv_flag & s_q.lowv_rst_en
                   & s_q.lowv_det_en; // RULE_12

    // APB answer: ready in the access cycle, data sampled at setup.
    // The read word is captured at setup, so it stands through the access cycle.
    s_d.pready  = psel_i & ~penable_i;
    s_d.pslverr = 1'b0;
    if (psel_i && !penable_i)
    begin
      s_d.prdata = 32'h0000_0000;
      unique case (paddr_i)
        `SCR_OFF_CLKOUT:
        begin
          s_d.prdata[`SCR_CLKOUT_EN_BIT] = s_q.clkout_en;
          s_d.prdata[2:0]                = s_q.clkout_sel;
        end
        `SCR_OFF_PARTID:
        begin
          // Reserved upper nibble reads zero; the register ignores writes.
          s_d.prdata[3:0] = 4'(`SCR_PART_ID >> 8); // RULE_04 RULE_05
        end
        `SCR_OFF_PMSC1:
        begin
          // Acknowledge and reserved bit 1 always read zero.
          s_d.prdata[`SCR_PM_FLAG_BIT]   = s_q.lowv_flag;
          s_d.prdata[`SCR_PM_IRQEN_BIT]  = s_q.lowv_irq_en;
          s_d.prdata[`SCR_PM_RSTEN_BIT]  = s_q.lowv_rst_en;
          s_d.prdata[`SCR_PM_STOPEN_BIT] = s_q.lowv_stop_en;
          s_d.prdata[`SCR_PM_DETEN_BIT]  = s_q.lowv_det_en;
          s_d.prdata[`SCR_PM_BGEN_BIT]   = s_q.bg_en;
        end
        `SCR_OFF_WAKE:
        begin
          s_d.prdata[2:0]               = s_q.wake_sel;
          s_d.prdata[`SCR_WAKE_EXT_BIT] = s_q.wake_ext;
        end
        `SCR_OFF_IRQ_STAT:
        begin
          s_d.prdata[1:0] = s_q.irq_stat;
        end
        `SCR_OFF_IRQ_CLR:
        begin
          s_d.prdata[1:0] = 2'h0;
        end
        `SCR_OFF_IRQ_EN:
        begin
          s_d.prdata[1:0] = s_q.irq_en;
        end
        default:
        begin
          s_d.pslverr = 1'b1;
        end
      endcase
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Only the write-once power bits start set; all else clears.
      s_q              <= '0;
      s_q.lowv_rst_en  <= PM_RESET[`SCR_PM_RSTEN_BIT];
      s_q.lowv_stop_en <= PM_RESET[`SCR_PM_STOPEN_BIT];
      s_q.lowv_det_en  <= PM_RESET[`SCR_PM_DETEN_BIT];
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // Outputs, all from flip-flops
  // ************************************************************
  // Drive the ports from the registered state.
  assign pready_o            = s_q.pready;
  assign pslverr_o           = s_q.pslverr;
  assign prdata_o            = s_q.prdata;
  assign clkout_port_pin_o   = div_clk; // RULE_01
  assign clkout_pin_enable_o = s_q.clkout_en;
  assign irq_o               = s_q.irq;
  assign lowv_reset_req_o    = s_q.lowv_reset;

endmodule : scr_top

// file: src/scr_wakeup_timer.sv
// Purpose: Periodic wakeup timer counting ticks of a chosen source.
// Assumes: step_i is a one-cycle pulse per source tick.
// Notes:   A change of select takes effect on the running count.
`timescale 1ns/1ps
module scr_wakeup_timer
  import scr_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       step_i,
  input  wire logic       ext_i,
  input  wire logic [2:0] sel_i,
  // Event
  output logic            wake_o
);

  scr_wake_state_type s_q;
  scr_wake_state_type s_d;
  logic [15:0]        limit;

  // Ticks per period; 1 kHz ticks are milliseconds.
  always_comb
  begin
    limit = 16'h0001;
    unique case ({ext_i, sel_i})
      4'h1: limit = 16'h0008; // RULE_07
      4'h2: limit = 16'h0020;
      4'h3: limit = 16'h0040;
      4'h4: limit = 16'h0080;
      4'h5: limit = 16'h0100;
      4'h6: limit = 16'h0200;
      4'h7: limit = 16'h0400;
      4'h9: limit = 16'h0100; // RULE_08
      4'hA: limit = 16'h0400;
      4'hB: limit = 16'h0800;
      4'hC: limit = 16'h1000;
      4'hD: limit = 16'h2000;
      4'hE: limit = 16'h4000;
      4'hF: limit = 16'h8000;
      default: limit = 16'h0001;
    endcase
  end

  // Count source ticks and pulse once per period.
  always_comb
  begin
    s_d      = s_q;
    s_d.wake = 1'b0;
    if (sel_i == 3'h0)
    begin
      s_d.cnt = 16'h0000; // RULE_06
    end
    else if (step_i)
    begin
      if (s_q.cnt >= 16'(limit - 16'h0001))
      begin
        s_d.cnt  = 16'h0000;
        s_d.wake = 1'b1;
      end
      else
      begin
        s_d.cnt = 16'(s_q.cnt + 16'h0001);
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign wake_o = s_q.wake;

endmodule : scr_wakeup_timer

// file: verification/scr_top_bench.sv
// Purpose: Self-checking bench for the system-control register block.
// Assumes: Tick shortened to 4 bus clocks; external clock is clk/4.
// Notes:   Random selects and unmapped addresses use seed 33.
`timescale 1ns/1ps
`include "scr_defs.svh"
module scr_top_bench;
  localparam int TICK = 4;
  localparam logic [11:0] PID = `SCR_PART_ID;
  logic        clk_sys_i = 0, reset_n_i = 0, psel_i = 0, penable_i = 0;
  logic        pwrite_i = 0, lowv_detect_i = 0, er, acc;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, rd;
  logic [1:0]  ext_cnt_q = 0;
  wire logic   ext_clk_i, pready_o, pslverr_o, pin, pin_en, irq_o, req;
  wire logic [31:0] prdata_o;
  int          bad_count = 0, num_checks = 0, hi, per, s;
  always #20 clk_sys_i = ~clk_sys_i;
  // External wakeup clock, well below half the bus clock.
  always @(posedge clk_sys_i) ext_cnt_q <= ext_cnt_q + 2'h1;
  assign ext_clk_i = ext_cnt_q[1];
  scr_top #(.TICK_CYCLES(TICK)) i_scr_top (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o),
    .lowv_detect_i(lowv_detect_i), .ext_clk_i(ext_clk_i), .clkout_port_pin_o(pin),
    .clkout_pin_enable_o(pin_en), .irq_o(irq_o), .lowv_reset_req_o(req));
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : cyc
  // One APB transfer; the request stands until ready is seen high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1;
    // No timeout here; if ready never comes, only the watchdog ends this wait.
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask : apb
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
    check(er, 1'b0);
  endtask : rdc
  task low20;
    acc = 0;
    repeat (20) begin @(posedge clk_sys_i); acc |= pin; end
  endtask : low20
  // Measures the high time and period from a clean rising edge.
  task pin_meas;
    int n;
    n = 0;
    while (pin !== 0 && n < 99) begin @(posedge clk_sys_i); n++; end
    while (pin !== 1 && n < 99) begin @(posedge clk_sys_i); n++; end
    hi = 0;
    while (pin === 1 && hi < 99) begin @(posedge clk_sys_i); hi++; end
    per = hi;
    while (pin === 0 && per < 99) begin @(posedge clk_sys_i); per++; end
  endtask : pin_meas
  // Rise to rise of the wakeup interrupt, clearing status between.
  task wake_meas;
    int n;
    time t0;
    n = 0;
    while (irq_o !== 1 && n < 9000) begin @(posedge clk_sys_i); n++; end
    t0 = $time;
    wr(12'h014, 32'h2);
    while (irq_o !== 0 && n < 9000) begin @(posedge clk_sys_i); n++; end
    while (irq_o !== 1 && n < 18000) begin @(posedge clk_sys_i); n++; end
    per = int'(($time - t0) / 40);
  endtask : wake_meas
  function automatic int exp_wake(input logic ext, input int k);
    int ms[8] = '{0, 8, 32, 64, 128, 256, 512, 1024};
    int dv[8] = '{0, 256, 1024, 2048, 4096, 8192, 16384, 32768};
    return ext ? dv[k] * 4 : ms[k] * TICK;
  endfunction : exp_wake
  task lv_pulse;
    lowv_detect_i <= 1;
    cyc(4);
    lowv_detect_i <= 0;
    cyc(3);
  endtask : lv_pulse
  initial begin #(40 * 70000); bad_count++; final_report; end
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    void'($urandom(33));
    cyc(5); reset_n_i <= 1; cyc(3);
    rdc(12'h008, 32'h1C);
    rdc(12'h004, {28'h0, PID[11:8]});
    wr(12'h004, 32'hFF);
    rdc(12'h004, {28'h0, PID[11:8]});
    apb(1'b0, 12'h100 + 12'(4 * $urandom_range(0, 700)), 32'h0);
    check(er, 1'b1);
    check(rd, 32'h0);
    wr(12'h008, 32'h34);
    wr(12'h008, 32'h00);
    rdc(12'h008, 32'h14);
    wr(12'h008, 32'h20);
    lv_pulse;
    check({irq_o, req}, 2'b11);
    rdc(12'h008, 32'hB4);
    rdc(12'h010, 32'h1);
    wr(12'h008, 32'h14); cyc(2);
    check({irq_o, req}, 2'b01);
    wr(12'h008, 32'h60); cyc(2);
    check({irq_o, req}, 2'b00);
    rdc(12'h008, 32'h34);
    wr(12'h018, 32'h1); cyc(2);
    check(irq_o, 1'b1);
    wr(12'h014, 32'h1); cyc(2);
    check(irq_o, 1'b0);
    rdc(12'h010, 32'h0);
    for (int i = 0; i < 11; i++)
    begin
      s = (i < 8) ? (i + 1) % 8 : $urandom_range(7, 1);
      wr(12'h000, 32'h10 | s);
      if (s == 0) begin cyc(1); low20; check(acc, 1'b0); end
      else
      begin
        pin_meas;
        check(hi, s);
        check(per, 2 * s);
      end
      check(pin_en, 1'b1);
    end
    wr(12'h000, 32'h03); cyc(1); low20;
    check({acc, pin_en}, 2'b00);
    wr(12'h018, 32'h2);
    for (int k = 1; k < 10; k++)
    begin
      s = (k < 8) ? k : k - 7;
      wr(12'h00C, 32'((k < 8) ? s : 8 | s)); wr(12'h014, 32'h2); cyc(2); wake_meas;
      check(per, exp_wake(k >= 8, s));
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(12'h00C, 32'(8 * k)); wr(12'h014, 32'h2); cyc(300);
      check(irq_o, 1'b0);
    end
    reset_n_i <= 0; cyc(5); reset_n_i <= 1; cyc(3);
    wr(12'h008, 32'h00); wr(12'h008, 32'h1C);
    lv_pulse;
    rdc(12'h008, 32'h0);
    check(req, 1'b0);
    final_report;
  end
endmodule : scr_top_bench

// file: verification/scr_top_monitor.sv
// Purpose: Port assertions for the system-control register block.
// Assumes: Sees only the ports of scr_top; attached by the bind below.
// Notes:   Internal state is inferred from the bus and pin traffic.
`timescale 1ns/1ps
`include "scr_defs.svh"
// ************************************************************
// Checker
// ************************************************************
module scr_top_monitor
#(
  parameter int TICK_CYCLES = 4
)
(
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  // APB
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic [31:0] prdata_o,
  // Pins and requests
  input wire logic        lowv_detect_i,
  input wire logic        ext_clk_i,
  input wire logic        clkout_port_pin_o,
  input wire logic        clkout_pin_enable_o,
  input wire logic        irq_o,
  input wire logic        lowv_reset_req_o
);
  localparam logic [11:0] PID = `SCR_PART_ID;
  logic setup;
  logic seen_lv_q;
  // A setup cycle is the only legal cause of an answer.
  assign setup = psel_i && !penable_i;
  // Remembers a raw low level; a reset request without one is spurious.
  always_ff @(posedge clk_sys_i or negedge reset_n_i)
    if (!reset_n_i)
      seen_lv_q <= 1'b0;
    else if (lowv_detect_i)
      seen_lv_q <= 1'b1;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  a_ready_after_setup: assert property (setup |=> pready_o)
    else $error("no ready after setup");
  a_ready_cause: assert property (pready_o |-> $past(setup) && penable_i)
    else $error("ready without request");
  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_err_unmapped: assert property (setup && paddr_i[11:5] != 0 |=> pslverr_o && pready_o)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && paddr_i <= 12'h018 && paddr_i[1:0] == 0 |=> !pslverr_o)
    else $error("mapped access refused");
  a_id_nibble: assert property (setup && !pwrite_i && paddr_i == 12'h004
    |=> prdata_o[3:0] == PID[11:8]) else $error("id nibble wrong");
  a_ack_reads_zero: assert property (setup && !pwrite_i && paddr_i == 12'h008
    |=> !prdata_o[6] && !prdata_o[1]) else $error("write-only bit read back");
  a_pin_idle_low: assert property (!clkout_pin_enable_o [*3] |-> !clkout_port_pin_o)
    else $error("clock pin active while disabled");
  a_req_needs_event: assert property (lowv_reset_req_o |-> seen_lv_q)
    else $error("reset request without low voltage");
  a_req_drop_cause: assert property ($fell(lowv_reset_req_o)
    |-> $past(setup && pwrite_i && paddr_i == 12'h008, 3)) else $error("request dropped alone");
  c_refused: cover property (pslverr_o);
  c_req_drop: cover property ($fell(lowv_reset_req_o));
  c_pin_rise: cover property ($rose(clkout_port_pin_o));
  c_irq_rise: cover property ($rose(irq_o));
endmodule : scr_top_monitor

bind scr_top scr_top_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_scr_top_monitor (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .prdata_o(prdata_o), .lowv_detect_i(lowv_detect_i),
  .ext_clk_i(ext_clk_i), .clkout_port_pin_o(clkout_port_pin_o),
  .clkout_pin_enable_o(clkout_pin_enable_o), .irq_o(irq_o),
  .lowv_reset_req_o(lowv_reset_req_o));
